// *** common/acs_pkg.sv ***
// Constants, modes and timing shared by both ends of the conversion sequencer
// Operation
// - Four modes: single, multi, continuous, turbo
// - Start by software bit or hardware input
// - Done status and completion held until read
// - Single mode waits in standby for start
// - Three priming conversions, result after fourth
// - Single returns to standby after transfer
// - Continuous: three-conversion latency, then every conversion
// - Do not switch input in continuous mode
// - Multi resets and re-primes decimator per sample
// - Multi sample auto-launches next sample
// - Hardware start optional in continuous mode
// - Completion rises at end of each result
// - Software may poll status instead
// - Output depends on last four samples
// - Input change invalidates until fourth sample
package acs_pkg;
   typedef enum logic [1:0] {
      ACS_MODE_SINGLE,
      ACS_MODE_MULTI,
      ACS_MODE_CONT,
      ACS_MODE_TURBO
   } acs_mode_t;
   localparam int ACS_CLK_PERIOD_NS = 20;
   // Duration of one modulator conversion
   localparam int ACS_CONV_TIME_NS = 1000;
   localparam int ACS_CONV_CYCLES = (ACS_CONV_TIME_NS + ACS_CLK_PERIOD_NS - 1) / ACS_CLK_PERIOD_NS;
   localparam int ACS_TAPS = 4;
   localparam int ACS_PRIME_CONV = 3;
   localparam int ACS_SAMPLE_W = 12;
   localparam int ACS_RESULT_W = 14;
   localparam int ACS_MUX_W = 4;
   localparam int ACS_FIFO_DEPTH = 8;
   localparam int ACS_SYNC_STAGES = 2;
endpackage

// *** common/acs_if.sv ***
// Link between the conversion sequencer and its reading party
`timescale 1ns/1ns
`default_nettype none
interface acs_if;
   import acs_pkg::*;
   logic start_sw;
   logic soc;
   logic stop;
   acs_mode_t mode;
   logic [ACS_MUX_W-1:0] mux_sel;
   logic [ACS_RESULT_W-1:0] res_data;
   logic res_valid;
   logic res_ready;
   logic eoc;
   modport dev (
      input start_sw, soc, stop, mode, mux_sel, res_ready,
      output res_data, res_valid, eoc
   );
   modport host (
      output start_sw, soc, stop, mode, mux_sel, res_ready,
      input res_data, res_valid, eoc
   );
endinterface
`default_nettype wire

// *** src/acs_host.sv ***
// Reading party: start control, trigger pin and result reader
`timescale 1ns/1ns
`default_nettype none
module acs_host (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Link to the sequencer
   acs_if.host link,
   // Command side
   input wire logic cmd_start,
   input wire logic cmd_stop,
   input wire acs_pkg::acs_mode_t cmd_mode,
   input wire logic [acs_pkg::ACS_MUX_W-1:0] cmd_mux,
   input wire logic trig_pin,
   // Result side
   input wire logic usr_ready,
   output logic [acs_pkg::ACS_RESULT_W-1:0] usr_data_q,
   output logic usr_valid_q,
   output logic done_q
);
   import acs_pkg::*;
   logic [ACS_SYNC_STAGES-1:0] trig_sync_q;
   logic trig_prev_q;
   logic start_q;
   logic soc_q;
   logic stop_q;
   acs_mode_t mode_q;
   logic [ACS_MUX_W-1:0] mux_q;
   logic ready_q;
   logic pop;
   logic usr_valid_d;

   // Trigger pin crosses in through two flops before the edge detector
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         trig_sync_q <= '0;
         trig_prev_q <= 1'b0;
      end else begin
         trig_sync_q <= {trig_sync_q[ACS_SYNC_STAGES-2:0], trig_pin};
         trig_prev_q <= trig_sync_q[ACS_SYNC_STAGES-1];
      end
   end

   // Start pulses from the command bit or the trigger edge
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         start_q <= 1'b0;
         soc_q <= 1'b0;
         stop_q <= 1'b0;
      end else begin
         start_q <= cmd_start;
         soc_q <= trig_sync_q[ACS_SYNC_STAGES-1] & ~trig_prev_q;
         stop_q <= cmd_stop;
      end
   end

   // Mode and input select are held; in continuous mode the select only updates on stop, otherwise a mid-run change restarts priming
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mode_q <= ACS_MODE_SINGLE;
         mux_q <= '0;
      end else begin
         mode_q <= cmd_mode;
         if (mode_q != ACS_MODE_CONT || cmd_stop) begin
            mux_q <= cmd_mux;
         end
      end
   end

   assign pop = link.res_valid & ready_q;
   always_comb begin
      usr_valid_d = usr_valid_q;
      if (usr_valid_q && usr_ready) begin
         usr_valid_d = 1'b0;
      end
      if (pop) begin
         usr_valid_d = 1'b1;
      end
   end

   // One-word holding stage; ready is registered from the next occupancy
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         usr_valid_q <= 1'b0;
         usr_data_q <= '0;
         ready_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         usr_valid_q <= usr_valid_d;
         ready_q <= ~usr_valid_d;
         done_q <= link.eoc;
         if (pop) begin
            usr_data_q <= link.res_data;
         end
      end
   end

   assign link.start_sw = start_q;
   assign link.soc = soc_q;
   assign link.stop = stop_q;
   assign link.mode = mode_q;
   assign link.mux_sel = mux_q;
   assign link.res_ready = ready_q;
endmodule
`default_nettype wire

// *** src/acs_device.sv ***
// Conversion sequencer with decimator window and result FIFO
`timescale 1ns/1ns
`default_nettype none
module acs_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_q[rd_q];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

module acs_device #(
   parameter int CONV_CYCLES = acs_pkg::ACS_CONV_CYCLES,
   parameter int FIFO_DEPTH = acs_pkg::ACS_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Link to the reading party
   acs_if.dev link,
   // Modulator side
   input wire logic [acs_pkg::ACS_SAMPLE_W-1:0] mod_data,
   output logic running_q,
   output logic conv_strobe_q
);
   import acs_pkg::*;
   localparam int CW = $clog2(CONV_CYCLES + 1);

   typedef enum {
      ACS_ST_STANDBY,
      ACS_ST_RUN,
      ACS_ST_XFER
   } acs_state_t;

   acs_state_t state_q;
   logic [CW-1:0] tick_q;
   logic [1:0] valid_q;
   logic [ACS_SAMPLE_W-1:0] win_q [ACS_TAPS-1];
   logic [ACS_MUX_W-1:0] mux_prev_q;
   logic [ACS_RESULT_W-1:0] sum;
   logic start_evt;
   logic conv_last;
   logic result_now;
   logic stall;
   logic conv_end;
   logic mux_change;
   logic reprime;
   logic fifo_ready;
   logic fifo_valid;
   logic eoc_q;

   assign start_evt = link.start_sw | link.soc;
   assign mux_change = (link.mux_sel != mux_prev_q);
   assign conv_last = (state_q == ACS_ST_RUN) && (tick_q == CW'(CONV_CYCLES - 1));
   // Fourth conversion of a window yields the result
   assign result_now = conv_last && (valid_q == 2'(ACS_PRIME_CONV));
   // A full FIFO holds the sequencer at the end of the conversion
   assign stall = result_now & ~fifo_ready;
   assign conv_end = conv_last & ~stall;
   // Multi and turbo clear the window after every result
   assign reprime = result_now & ~stall &
      (link.mode == ACS_MODE_MULTI || link.mode == ACS_MODE_TURBO);

   // Decimator: result is the sum of the last four samples
   always_comb begin
      sum = ACS_RESULT_W'(mod_data);
      for (int i = 0; i < ACS_TAPS - 1; i++) begin
         sum = sum + ACS_RESULT_W'(win_q[i]);
      end
   end

   // Sequencing state
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= ACS_ST_STANDBY;
      end else begin
         case (state_q)
            ACS_ST_STANDBY: begin
               if (start_evt && !link.stop) begin
                  state_q <= ACS_ST_RUN;
               end
            end
            ACS_ST_RUN: begin
               if (link.stop) begin
                  state_q <= ACS_ST_STANDBY;
               end else if (result_now && !stall && link.mode == ACS_MODE_SINGLE) begin
                  state_q <= ACS_ST_XFER;
               end
            end
            ACS_ST_XFER: begin
               // Wait for the reader to drain the result
               if (!fifo_valid || link.stop) begin
                  state_q <= ACS_ST_STANDBY;
               end
            end
            default: begin
               state_q <= ACS_ST_STANDBY;
            end
         endcase
      end
   end

   // Conversion timer; runs on without a new start in multi and continuous
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tick_q <= '0;
      end else if (state_q != ACS_ST_RUN || link.stop) begin
         tick_q <= '0;
      end else if (conv_end) begin
         tick_q <= '0;
      end else if (!stall) begin
         tick_q <= tick_q + 1'b1;
      end
   end

   // Priming count: three conversions before a valid result
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         valid_q <= '0;
      end else if (state_q == ACS_ST_STANDBY || mux_change) begin
         valid_q <= '0;
      end else if (reprime) begin
         valid_q <= '0;
      end else if (conv_end && valid_q != 2'(ACS_PRIME_CONV)) begin
         valid_q <= valid_q + 1'b1;
      end
   end

   // Sample window; stale samples are flushed on re-prime or input change
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < ACS_TAPS - 1; i++) begin
            win_q[i] <= '0;
         end
      end else if (reprime || mux_change || state_q == ACS_ST_STANDBY) begin
         for (int i = 0; i < ACS_TAPS - 1; i++) begin
            win_q[i] <= '0;
         end
      end else if (conv_end) begin
         win_q[0] <= mod_data;
         for (int i = 1; i < ACS_TAPS - 1; i++) begin
            win_q[i] <= win_q[i-1];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mux_prev_q <= '0;
      end else begin
         mux_prev_q <= link.mux_sel;
      end
   end

   // Completion stays high while any unread result remains; a new result wins
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         eoc_q <= 1'b0;
      end else if (result_now && !stall) begin
         eoc_q <= 1'b1;
      end else if (!fifo_valid) begin
         eoc_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         running_q <= 1'b0;
         conv_strobe_q <= 1'b0;
      end else begin
         running_q <= (state_q == ACS_ST_RUN);
         conv_strobe_q <= conv_end;
      end
   end

   acs_fifo #(
      .WIDTH(ACS_RESULT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(result_now),
      .in_ready(fifo_ready),
      .in_data(sum),
      .out_valid(fifo_valid),
      .out_ready(link.res_ready),
      .out_data(link.res_data)
   );

   assign link.res_valid = fifo_valid;
   assign link.eoc = eoc_q;
endmodule
`default_nettype wire

// *** verification/acs_props.sv ***
// Concurrent checks on the link between the two ends
`timescale 1ns/1ns
`default_nettype none
module acs_props #(
   parameter int CONV_CYCLES = acs_pkg::ACS_CONV_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Link signals
   input wire logic start_sw,
   input wire logic soc,
   input wire logic stop,
   input wire acs_pkg::acs_mode_t mode,
   input wire logic [acs_pkg::ACS_RESULT_W-1:0] res_data,
   input wire logic res_valid,
   input wire logic res_ready,
   input wire logic eoc
);
   import acs_pkg::*;
   localparam int LAT_LO = 4 * CONV_CYCLES - 1;
   localparam int LAT_HI = 4 * CONV_CYCLES + 3;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   property p_reset_quiet;
      $fell(reset) |-> !eoc && !res_valid && !start_sw;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("link busy after reset");
   property p_start_pulse;
      start_sw |=> !start_sw;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start held");
   // A single-mode start must not produce a result within the next eight cycles
   property p_no_early;
      (start_sw || soc) && mode == ACS_MODE_SINGLE && !eoc |=> !res_valid [*8];
   endproperty
   a_no_early: assert property (p_no_early) else $error("result too early");
   property p_on_time;
      (start_sw || soc) && mode == ACS_MODE_SINGLE && !eoc |-> ##[LAT_LO:LAT_HI] res_valid;
   endproperty
   a_on_time: assert property (p_on_time) else $error("result late");
   property p_eoc_rise;
      $rose(eoc) |-> res_valid;
   endproperty
   a_eoc_rise: assert property (p_eoc_rise) else $error("completion without result");
   // Stop is excluded, so holding is only promised in cycles where stop is low
   property p_eoc_hold;
      res_valid && !res_ready && !stop |=> eoc;
   endproperty
   a_eoc_hold: assert property (p_eoc_hold) else $error("completion dropped");
   property p_head_stable;
      res_valid && !res_ready && !stop |=> res_valid && $stable(res_data);
   endproperty
   a_head_stable: assert property (p_head_stable) else $error("result lost");
   property p_eoc_drop;
      !res_valid [*3] |-> !eoc;
   endproperty
   a_eoc_drop: assert property (p_eoc_drop) else $error("completion stuck");
endmodule
`default_nettype wire

// *** verification/adc_conversion_sequencer_tb.sv ***
// Bench joining host and sequencer, with a reference model of results
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer_tb;
   import acs_pkg::*;
   localparam int CONV = 4;
   logic clk_sys, reset, cmd_start, cmd_stop, trig_pin, usr_ready, rdy_en, run_d1;
   acs_mode_t cmd_mode;
   logic [ACS_MUX_W-1:0] cmd_mux;
   logic [ACS_SAMPLE_W-1:0] mod_data = '0;
   logic [ACS_RESULT_W-1:0] usr_data_q;
   logic usr_valid_q, done_q, running_q, conv_strobe_q;
   int errors, comparisons, seed, cnt, got, e;
   int win[$];
   // Words handed to the holding stage, in order, awaiting the user handshake
   int usr_q[$];
   int exp_q[$];
   acs_if link();
   acs_host acs_host_i (.clk_sys(clk_sys), .reset(reset), .link(link), .cmd_start(cmd_start),
      .cmd_stop(cmd_stop), .cmd_mode(cmd_mode), .cmd_mux(cmd_mux), .trig_pin(trig_pin),
      .usr_ready(usr_ready), .usr_data_q(usr_data_q), .usr_valid_q(usr_valid_q), .done_q(done_q));
   acs_device #(.CONV_CYCLES(CONV), .FIFO_DEPTH(8)) acs_device_i (.clk_sys(clk_sys),
      .reset(reset), .link(link), .mod_data(mod_data), .running_q(running_q),
      .conv_strobe_q(conv_strobe_q));
   acs_props #(.CONV_CYCLES(CONV)) acs_props_i (.clk_sys(clk_sys), .reset(reset),
      .start_sw(link.start_sw), .soc(link.soc), .stop(link.stop), .mode(link.mode),
      .res_data(link.res_data), .res_valid(link.res_valid), .res_ready(link.res_ready),
      .eoc(link.eoc));
   initial begin
      clk_sys = 0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic finish_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check_val(logic [ACS_RESULT_W-1:0] g, logic [ACS_RESULT_W-1:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("FAIL %0t got %0h exp %0h", $time, g, e);
      end
   endtask
   task automatic check_bit(logic g, logic e);
      check_val({13'h0, g}, {13'h0, e});
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic start_run(acs_mode_t m, bit hw);
      cmd_mode = m;
      cmd_mux = ACS_MUX_W'($random(seed));
      got = 0;
      tick(2);
      if (hw)
         trig_pin = 1;
      else
         cmd_start = 1;
      tick(1);
      cmd_start = 0;
      tick(4);
      trig_pin = 0;
   endtask
   task automatic wait_res(int n);
      int k;
      k = 0;
      while (got < n && k < 2000) begin
         tick(1);
         k++;
      end
      check_val(ACS_RESULT_W'(got >= n), 14'h1);
   endtask
   task automatic stop_run();
      cmd_stop = 1;
      tick(1);
      cmd_stop = 0;
      tick(30);
      exp_q.delete();
      usr_q.delete();
   endtask
   // Sample is taken at conversion end, so change it only after the strobe
   always @(posedge clk_sys) begin
      if (conv_strobe_q === 1'b1) begin
         #1;
         mod_data = ACS_SAMPLE_W'($random(seed));
      end
   end
   always @(posedge clk_sys) begin
      #1;
      usr_ready = rdy_en && (($random(seed) & 3) != 0);
   end
   always @(posedge clk_sys) begin
      if (running_q === 1'b1 && !run_d1) begin
         win.delete();
         cnt = 0;
      end
      run_d1 = running_q;
      if (conv_strobe_q === 1'b1) begin
         win.push_back(int'(mod_data));
         if (win.size() > 4)
            void'(win.pop_front());
         cnt++;
         if (cnt >= 4) begin
            exp_q.push_back(win.sum());
            if (cmd_mode != ACS_MODE_CONT) begin
               cnt = 0;
               win.delete();
            end
         end
      end
      if (usr_valid_q === 1'b1 && usr_ready === 1'b1) begin
         check_val(usr_data_q, ACS_RESULT_W'(usr_q.pop_front()));
      end
      if (link.res_valid === 1'b1 && link.res_ready === 1'b1) begin
         got++;
         e = exp_q.pop_front();
         check_val(link.res_data, ACS_RESULT_W'(e));
         usr_q.push_back(e);
      end
   end
   initial begin
      repeat (6000) @(posedge clk_sys);
      errors++;
      finish_test();
   end
   initial begin
      seed = 62;
      reset = 1;
      {cmd_start, cmd_stop, trig_pin, rdy_en} = '0;
      cmd_mode = ACS_MODE_SINGLE;
      cmd_mux = '0;
      repeat (6) @(posedge clk_sys);
      #1;
      reset = 0;
      tick(2);
      rdy_en = 1;
      for (int h = 0; h < 2; h++) begin
         start_run(ACS_MODE_SINGLE, h[0]);
         wait_res(1);
         tick(40);
         check_bit(running_q, 1'b0);
         check_bit(link.eoc, 1'b0);
         check_val(ACS_RESULT_W'(got), 14'h1);
      end
      start_run(ACS_MODE_MULTI, 0);
      wait_res(3);
      stop_run();
      start_run(ACS_MODE_TURBO, 1);
      wait_res(3);
      stop_run();
      // Hold the reader off so the FIFO fills and stalls the converter
      rdy_en = 0;
      start_run(ACS_MODE_CONT, 0);
      tick(100);
      check_bit(link.res_valid, 1'b1);
      check_bit(done_q, 1'b1);
      rdy_en = 1;
      wait_res(12);
      stop_run();
      check_bit(link.res_valid, 1'b0);
      check_bit(link.eoc, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
